// ===== design/mfs_pkg.sv
// Constants, types and a helper function for the flow meter serial slave.
// Assumes a single 20 MHz system clock shared by every user of the package.
package mfs_pkg;

    // System clock rate and the eight selectable bit rates.
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam logic [15:0] BIT_CYC [8] = '{
        16'(CLK_HZ / 1200), 16'(CLK_HZ / 2400), 16'(CLK_HZ / 4800),
        16'(CLK_HZ / 9600), 16'(CLK_HZ / 19200), 16'(CLK_HZ / 38400),
        16'(CLK_HZ / 57600), 16'(CLK_HZ / 115200)};

    // Timing of the response delay, one unit being one millisecond.
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned RESP_UNIT_NS = 1_000_000;
    localparam int unsigned MS_CYC = RESP_UNIT_NS / CLK_PERIOD_NS;

    // Character framing and idle gap that ends a frame in RTU mode.
    localparam int unsigned CHAR_BITS = 10;
    localparam int unsigned GAP_CHARS_RST = 7;

    // Values after reset, the highest accepted address and the CRC constants.
    localparam logic [2:0] BAUD_SEL_RST = 3'h4;
    localparam logic [7:0] ADDR_AUTO = 8'h00;
    localparam logic [7:0] ADDR_MAX = 8'hfb;
    localparam logic [7:0] RESP_MS_RST = 8'h00;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;

    // Protocol codes.
    localparam logic [7:0] FUNC_READ = 8'h03;
    localparam logic [7:0] FUNC_EXC = 8'h80;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_QTY = 8'h03;
    localparam logic [7:0] QTY_MAX = 8'h7d;
    localparam logic [7:0] CH_COLON = 8'h3a;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] RTU_REQ_LEN = 8'h08;
    localparam logic [7:0] ASC_REQ_LEN = 8'h07;

    // Register addresses of the six measurement values.
    localparam logic [15:0] REG_VEL = 16'h0000;
    localparam logic [15:0] REG_FLOW = 16'h0006;
    localparam logic [15:0] REG_FWD = 16'h000c;
    localparam logic [15:0] REG_BWD = 16'h0012;
    localparam logic [15:0] REG_GAS_T = 16'h0018;
    localparam logic [15:0] REG_AMB_T = 16'h0024;

    // Link configuration.
    typedef struct packed {
        logic       ascii;
        logic [2:0] baud_sel;
        logic [7:0] addr;
        logic [7:0] resp_ms;
    } mfs_cfg_t;

    localparam mfs_cfg_t CFG_RST = '{1'b0, BAUD_SEL_RST, ADDR_AUTO,
        RESP_MS_RST};

    // Measurement values offered to the master.
    typedef struct packed {
        logic [31:0] gas_velocity_value;
        logic [31:0] volume_flow_value;
        logic [31:0] forward_total_counter;
        logic [31:0] backward_total_counter;
        logic [31:0] gas_temperature_value;
        logic [31:0] surrounding_temperature_value;
    } mfs_meas_t;

    // One byte step of the reflected CRC-16.
    function automatic logic [15:0] crc_step(input logic [15:0] c,
        input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

endpackage

// ===== design/mfs_slave.sv
// Serial slave of the flow meter: receives read requests, answers them.
// Assumes an external RS485 transceiver; rx_i is asynchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none
module mfs_slave
    import mfs_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = mfs_pkg::MS_CYC,
    parameter int unsigned GAP_CHARS = mfs_pkg::GAP_CHARS_RST
)
(
    input wire logic clk_i, // System clock, 20 MHz.
    input wire logic sys_rst_i, // Synchronous reset, active high.
    input wire logic rx_i, // Receive data from the line.
    output logic tx_o, // Transmit data to the line.
    output logic line_oe_n_o, // Low while the slave drives the line.
    input wire mfs_pkg::mfs_cfg_t cfg_i, // New configuration.
    input wire logic cfg_load_i, // Pulse: take cfg_i.
    input wire logic [7:0] serial_lo_i, // Last two serial digits, binary.
    input wire mfs_pkg::mfs_meas_t meas_i // Live measurement values.
);
    import mfs_pkg::*;

    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} mfs_rx_t;
    typedef enum {M_RX, M_WAIT, M_LEAD, M_BODY, M_CR, M_LF, M_END} mfs_st_t;

    mfs_cfg_t cfg_q;
    logic rx_s1_q, rx_s2_q;
    mfs_rx_t rx_st_q;
    logic [15:0] rx_cnt_q;
    logic [2:0] rx_bit_q;
    logic [7:0] rx_sh_q;
    logic rx_stb_q;
    logic [23:0] gap_q;
    logic [7:0] buf_q [6];
    logic [7:0] nb_q;
    logic [15:0] chk_q;
    logic [3:0] hi_q;
    logic half_q, in_frame_q;
    mfs_st_t st_q;
    logic exc_q;
    logic [7:0] code_q, qty_q;
    logic [15:0] start_q;
    logic [7:0] ms_left_q;
    logic [23:0] ms_cyc_q;
    logic [8:0] k_q;
    logic nib_q;
    logic [15:0] txc_q;
    logic [9:0] tx_sh_q;
    logic [3:0] tx_bits_q;
    logic line_oe_n_q;
    logic [15:0] rx_cnt_tx_q;

    logic [15:0] bit_cyc;
    logic [23:0] gap_cyc;
    logic [7:0] my_addr;
    logic push;
    logic [7:0] push_b;
    logic [4:0] hexv;
    logic frame_end, ok, take;
    logic [8:0] plen, nbin;
    logic [7:0] cur_b, ch;
    logic send, byte_done;

    // Decodes an ASCII hex digit; bit 4 flags a valid digit.
    function automatic logic [4:0] hex_val(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39)
            return {1'b1, 4'(c - 8'h30)};
        else if (c >= 8'h41 && c <= 8'h46)
            return {1'b1, 4'(c - 8'h37)};
        else
            return 5'h00;
    endfunction

    // Picks the 16-bit word at a register address; gaps read as zero.
    function automatic logic [15:0] reg_word(input logic [15:0] a,
        input mfs_meas_t m);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a[15:1] == REG_VEL[15:1])
            v = m.gas_velocity_value;
        else if (a[15:1] == REG_FLOW[15:1])
            v = m.volume_flow_value;
        else if (a[15:1] == REG_FWD[15:1])
            v = m.forward_total_counter;
        else if (a[15:1] == REG_BWD[15:1])
            v = m.backward_total_counter;
        else if (a[15:1] == REG_GAS_T[15:1])
            v = m.gas_temperature_value;
        else if (a[15:1] == REG_AMB_T[15:1])
            v = m.surrounding_temperature_value;
        // Low word (bytes 1, 0) first, then high word (bytes 3, 2).
        return a[0] ? v[31:16] : v[15:0];
    endfunction

    // Configuration; out-of-range addresses are refused whole.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            cfg_q <= CFG_RST;
        else if (cfg_load_i && cfg_i.addr <= ADDR_MAX)
            cfg_q <= cfg_i;
    end

    // An address of zero means none was configured.
    assign my_addr = (cfg_q.addr == ADDR_AUTO) ? serial_lo_i : cfg_q.addr;
    assign bit_cyc = BIT_CYC[cfg_q.baud_sel];
    assign gap_cyc = 24'(bit_cyc) * 24'(CHAR_BITS * GAP_CHARS);

    // Two-stage synchroniser for the line input.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end
        else
        begin
            rx_s1_q <= rx_i;
            rx_s2_q <= rx_s1_q;
        end
    end

    // Receiver: samples mid-bit; a bad stop bit drops the character.
    always_ff @(posedge clk_i)
    begin
        rx_stb_q <= 1'b0;
        if (sys_rst_i)
        begin
            rx_st_q <= RX_IDLE;
            rx_cnt_q <= 16'h0000;
            rx_bit_q <= 3'h0;
            rx_sh_q <= 8'h00;
        end
        else
        begin
            rx_cnt_q <= rx_cnt_q + 16'h0001;
            case (rx_st_q)
                RX_IDLE:
                begin
                    rx_cnt_q <= 16'h0000;
                    if (!rx_s2_q)
                        rx_st_q <= RX_START;
                end
                RX_START:
                    if (rx_cnt_q == (bit_cyc >> 1))
                    begin
                        rx_cnt_q <= 16'h0000;
                        rx_bit_q <= 3'h0;
                        rx_st_q <= rx_s2_q ? RX_IDLE : RX_DATA;
                    end
                RX_DATA:
                    if (rx_cnt_q == bit_cyc - 16'h0001)
                    begin
                        rx_cnt_q <= 16'h0000;
                        rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == 3'h7)
                            rx_st_q <= RX_STOP;
                    end
                default:
                    if (rx_cnt_q == bit_cyc - 16'h0001)
                    begin
                        rx_st_q <= RX_IDLE;
                        rx_stb_q <= rx_s2_q;
                    end
            endcase
        end
    end

    // Idle time on the line, saturating at the frame gap.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || !rx_s2_q || rx_st_q != RX_IDLE)
            gap_q <= 24'h00_0000;
        else if (gap_q != gap_cyc)
            gap_q <= gap_q + 24'h00_0001;
    end

    // Byte assembly: RTU bytes as received, ASCII from hex pairs.
    always_comb
    begin
        hexv = hex_val(rx_sh_q);
        push = 1'b0;
        push_b = rx_sh_q;
        if (rx_stb_q && st_q == M_RX)
        begin
            if (!cfg_q.ascii)
                push = 1'b1;
            else if (in_frame_q && half_q && hexv[4])
            begin
                push = 1'b1;
                push_b = {hi_q, hexv[3:0]};
            end
        end
        frame_end = (st_q == M_RX) && (cfg_q.ascii
            ? (rx_stb_q && in_frame_q && rx_sh_q == CH_LF)
            : (gap_q == gap_cyc && nb_q != 8'h00));
        ok = cfg_q.ascii ? (chk_q[7:0] == 8'h00 && !half_q)
                         : (chk_q == 16'h0000);
        take = frame_end && ok && buf_q[0] == my_addr;
    end

    // Frame buffer with running CRC or LRC over every byte.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || frame_end || st_q != M_RX)
        begin
            nb_q <= 8'h00;
            chk_q <= cfg_q.ascii ? 16'h0000 : CRC_INIT;
            half_q <= 1'b0;
            in_frame_q <= 1'b0;
        end
        else if (cfg_q.ascii && rx_stb_q && rx_sh_q == CH_COLON)
        begin
            // A colon always restarts the frame.
            nb_q <= 8'h00;
            chk_q <= 16'h0000;
            half_q <= 1'b0;
            in_frame_q <= 1'b1;
        end
        else if (cfg_q.ascii && rx_stb_q && in_frame_q)
        begin
            if (hexv[4])
                half_q <= !half_q;
            else if (rx_sh_q != CH_CR)
                in_frame_q <= 1'b0;
            hi_q <= hexv[3:0];
        end
        if (push && !sys_rst_i && !frame_end)
        begin
            if (nb_q < 8'h06)
                buf_q[nb_q[2:0]] <= push_b;
            if (nb_q != 8'hff)
                nb_q <= nb_q + 8'h01;
            chk_q <= cfg_q.ascii ? {8'h00, chk_q[7:0] + push_b}
                                 : crc_step(chk_q, push_b);
        end
    end

    // Payload: address, function, count or code, then register bytes.
    always_comb
    begin
        plen = exc_q ? 9'h003 : 9'(9'h003 + {qty_q, 1'b0});
        nbin = plen + (cfg_q.ascii ? 9'h001 : 9'h002);
        if (k_q == 9'h000)
            cur_b = my_addr;
        else if (k_q == 9'h001)
            cur_b = exc_q ? (code_q == EXC_FUNC ? FUNC_EXC | buf_q[1]
                                                : FUNC_EXC | FUNC_READ)
                          : FUNC_READ;
        else if (k_q == 9'h002)
            cur_b = exc_q ? code_q : 8'({qty_q, 1'b0});
        else if (k_q < plen)
        begin
            // Each word goes high byte first.
            cur_b = 8'((k_q[0] ? reg_word(start_q
                + 16'((k_q - 9'h003) >> 1), meas_i) >> 8
                : reg_word(start_q + 16'((k_q - 9'h003) >> 1), meas_i))
                & 16'h00ff);
        end
        else if (k_q == plen)
            cur_b = cfg_q.ascii ? 8'(8'h00 - txc_q[7:0]) : txc_q[7:0];
        else
            cur_b = txc_q[15:8];
        case (st_q)
            M_LEAD: ch = CH_COLON;
            M_CR: ch = CH_CR;
            M_LF: ch = CH_LF;
            default:
            begin
                ch = nib_q ? {4'h0, cur_b[3:0]} : {4'h0, cur_b[7:4]};
                ch = (ch < 8'h0a) ? ch + 8'h30 : ch + 8'h37;
                if (!cfg_q.ascii)
                    ch = cur_b;
            end
        endcase
        send = (st_q == M_LEAD || st_q == M_BODY || st_q == M_CR
            || st_q == M_LF) && tx_bits_q == 4'h0;
        byte_done = send && st_q == M_BODY && (!cfg_q.ascii || nib_q);
    end

    // Control: transmits only after a valid addressed request.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            st_q <= M_RX;
            exc_q <= 1'b0;
            code_q <= 8'h00;
            qty_q <= 8'h00;
            start_q <= 16'h0000;
            ms_left_q <= 8'h00;
            ms_cyc_q <= 24'h00_0000;
            k_q <= 9'h000;
            nib_q <= 1'b0;
            txc_q <= CRC_INIT;
        end
        else
        begin
            case (st_q)
                M_RX:
                    if (take)
                    begin
                        start_q <= {buf_q[2], buf_q[3]};
                        qty_q <= buf_q[5];
                        ms_left_q <= cfg_q.resp_ms;
                        ms_cyc_q <= 24'h00_0000;
                        k_q <= 9'h000;
                        nib_q <= 1'b0;
                        txc_q <= cfg_q.ascii ? 16'h0000 : CRC_INIT;
                        if (buf_q[1] != FUNC_READ)
                        begin
                            exc_q <= 1'b1;
                            code_q <= EXC_FUNC;
                            st_q <= M_WAIT;
                        end
                        else if (nb_q == (cfg_q.ascii ? ASC_REQ_LEN
                                                      : RTU_REQ_LEN))
                        begin
                            exc_q <= buf_q[4] != 8'h00 || buf_q[5] == 8'h00
                                || buf_q[5] > QTY_MAX;
                            code_q <= EXC_QTY;
                            st_q <= M_WAIT;
                        end
                    end
                M_WAIT:
                    if (ms_left_q == 8'h00)
                        st_q <= cfg_q.ascii ? M_LEAD : M_BODY;
                    else if (ms_cyc_q == 24'(CYC_PER_MS - 1))
                    begin
                        ms_cyc_q <= 24'h00_0000;
                        ms_left_q <= ms_left_q - 8'h01;
                    end
                    else
                        ms_cyc_q <= ms_cyc_q + 24'h00_0001;
                M_LEAD:
                    if (send)
                        st_q <= M_BODY;
                M_BODY:
                begin
                    if (send && cfg_q.ascii)
                        nib_q <= !nib_q;
                    if (byte_done)
                    begin
                        if (k_q < plen)
                            txc_q <= cfg_q.ascii
                                ? {8'h00, txc_q[7:0] + cur_b}
                                : crc_step(txc_q, cur_b);
                        k_q <= k_q + 9'h001;
                        if (k_q == nbin - 9'h001)
                            st_q <= cfg_q.ascii ? M_CR : M_END;
                    end
                end
                M_CR:
                    if (send)
                        st_q <= M_LF;
                M_LF:
                    if (send)
                        st_q <= M_END;
                default:
                    if (tx_bits_q == 4'h0)
                        st_q <= M_RX;
            endcase
        end
    end

    // Transmitter: start, eight data bits LSB first, one stop bit.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            tx_sh_q <= 10'h3ff;
            tx_bits_q <= 4'h0;
        end
        else if (send)
        begin
            tx_sh_q <= {1'b1, ch, 1'b0};
            tx_bits_q <= 4'(CHAR_BITS);
        end
        else if (tx_bits_q != 4'h0 && rx_cnt_tx_q == bit_cyc - 16'h0001)
        begin
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            tx_bits_q <= tx_bits_q - 4'h1;
        end
    end

    // Bit timer of the transmitter.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || send || rx_cnt_tx_q == bit_cyc - 16'h0001)
            rx_cnt_tx_q <= 16'h0000;
        else
            rx_cnt_tx_q <= rx_cnt_tx_q + 16'h0001;
    end

    // The line is driven only while a reply is in flight.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            line_oe_n_q <= 1'b1;
        else
            line_oe_n_q <= !(st_q == M_LEAD || st_q == M_BODY
                || st_q == M_CR || st_q == M_LF || tx_bits_q != 4'h0);
    end

    assign tx_o = tx_sh_q[0];
    assign line_oe_n_o = line_oe_n_q;

endmodule
`default_nettype wire

// ===== bench/mfs_master_model.sv
// Bus master model: sends and receives 8N1 characters on the shared wire.
// Assumes the bench resolves the wire and that the slave is set to match.
`timescale 1ns/1ns
`default_nettype none
module mfs_master_model
(
    input wire logic clk_i, // System clock.
    input wire logic line_i, // Resolved wire level.
    output logic drv_o // Master level; high when released (bias).
);
    // Cycles per bit; fixed at the top rate, which the bench loads into the slave.
    int bit_cyc = int'(mfs_pkg::BIT_CYC[7]);

    initial drv_o = 1'b1;

    // One character, start bit, LSB first, stop bit; changes off the edge.
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(negedge clk_i);
            drv_o = f[i];
            repeat (bit_cyc - 1) @(negedge clk_i);
        end
    endtask

    // Waits a bounded time for a start bit, then samples mid-bit.
    task automatic recv_byte(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        b = 8'h00;
        while (line_i !== 1'b0 && n < 40 * bit_cyc)
        begin
            @(negedge clk_i);
            n++;
        end
        ok = (line_i === 1'b0);
        repeat (bit_cyc / 2) @(negedge clk_i);
        for (int i = 0; i < 8; i++)
        begin
            repeat (bit_cyc) @(negedge clk_i);
            b[i] = line_i;
        end
        repeat (bit_cyc) @(negedge clk_i);
        ok = ok && (line_i === 1'b1);
    endtask

    // Host storing the most significant byte first rebuilds 3-2-1-0.
    function automatic logic [31:0] to_msb(input logic [7:0] q0,
        input logic [7:0] q1, input logic [7:0] q2, input logic [7:0] q3);
        return {q2, q3, q0, q1};
    endfunction

    // Host storing the least significant byte first keeps 0-1-2-3.
    function automatic logic [31:0] to_lsb(input logic [7:0] q0,
        input logic [7:0] q1, input logic [7:0] q2, input logic [7:0] q3);
        return {q1, q0, q3, q2};
    endfunction
endmodule
`default_nettype wire

// ===== bench/mfs_slave_chk.sv
// Port checker for the serial slave, bound onto every mfs_slave.
// Assumes settings are only loaded while the line is quiet.
`timescale 1ns/1ns
`default_nettype none
module mfs_slave_chk
    import mfs_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = mfs_pkg::MS_CYC,
    parameter int unsigned GAP_CHARS = mfs_pkg::GAP_CHARS_RST
)
(
    input wire logic clk_i, // System clock.
    input wire logic sys_rst_i, // Reset.
    input wire logic rx_i, // Line in.
    input wire logic tx_o, // Line out.
    input wire logic line_oe_n_o, // Drive enable, low active.
    input wire mfs_pkg::mfs_cfg_t cfg_i, // Offered settings.
    input wire logic cfg_load_i // Settings load pulse.
);
    logic asc_q;
    logic [2:0] sel_q;
    logic [7:0] ms_q;
    logic [31:0] idle_q;
    logic [31:0] run_q;
    logic [31:0] oe_q;
    logic [31:0] bit_c;

    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    assign bit_c = 32'(BIT_CYC[sel_q]);

    // Shadow of the settings, so the timing figures follow the live rate.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            asc_q <= 1'b0;
            sel_q <= BAUD_SEL_RST;
            ms_q <= RESP_MS_RST;
        end
        else if (cfg_load_i && cfg_i.addr <= ADDR_MAX)
        begin
            asc_q <= cfg_i.ascii;
            sel_q <= cfg_i.baud_sel;
            ms_q <= cfg_i.resp_ms;
        end
    end

    // Run lengths of line idle, output level and drive time.
    always_ff @(posedge clk_i)
    begin
        idle_q <= rx_i ? idle_q + 32'h0000_0001 : 32'h0000_0000;
        run_q <= $changed(tx_o) ? 32'h0000_0000 : run_q + 32'h0000_0001;
        oe_q <= line_oe_n_o ? 32'h0000_0000 : oe_q + 32'h0000_0001;
    end

    a_idle_when_off: assert property (line_oe_n_o |-> tx_o)
        else $error("line not idle while released");
    a_reset_quiet: assert property (disable iff (1'b0)
        sys_rst_i |=> tx_o && line_oe_n_o)
        else $error("line driven during reset");
    a_start_follows: assert property ($fell(line_oe_n_o)
        |-> ##[0:4] !tx_o)
        else $error("no start bit after drive enable");
    a_stop_release: assert property ($rose(line_oe_n_o) |-> $past(tx_o))
        else $error("line released before stop bit");
    a_bit_length: assert property ($changed(tx_o) && !line_oe_n_o
        && $past(!line_oe_n_o) |-> run_q + 2 >= bit_c)
        else $error("bit shorter than bit time");
    a_frame_gap: assert property ($fell(line_oe_n_o) && !asc_q
        |-> idle_q >= GAP_CHARS * CHAR_BITS * bit_c)
        else $error("reply before frame gap");
    a_resp_delay: assert property ($fell(line_oe_n_o)
        |-> idle_q >= 32'(ms_q) * CYC_PER_MS)
        else $error("reply before response delay");
    a_reply_min: assert property ($rose(line_oe_n_o)
        |-> oe_q + 3 >= 5 * CHAR_BITS * bit_c)
        else $error("reply too short");

    c_rtu_reply: cover property ($fell(line_oe_n_o) && !asc_q);
    c_asc_reply: cover property ($fell(line_oe_n_o) && asc_q);
    c_bad_load: cover property (cfg_load_i && cfg_i.addr > ADDR_MAX);
endmodule

bind mfs_slave mfs_slave_chk #(
    .CYC_PER_MS(CYC_PER_MS),
    .GAP_CHARS(GAP_CHARS)
) mfs_slave_chk_i (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .rx_i(rx_i),
    .tx_o(tx_o),
    .line_oe_n_o(line_oe_n_o),
    .cfg_i(cfg_i),
    .cfg_load_i(cfg_load_i)
);
`default_nettype wire

// ===== bench/mfs_slave_bench.sv
// Bench for the serial slave: RTU and ASCII reads through a master model.
// Assumes the slave, its checker and the master model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module mfs_slave_bench;
    import mfs_pkg::*;
    localparam int CHAR = 10 * int'(BIT_CYC[7]);
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic load = 1'b0;
    logic [7:0] serial = 8'h2a;
    mfs_cfg_t cfg = CFG_RST;
    mfs_meas_t meas = '{32'h1122_3344, 32'h0bad_0002, 32'h0bad_0003,
        32'h0bad_0004, 32'h0bad_0005, 32'h5566_7788};
    logic tx;
    logic oe_n;
    logic m_drv;
    logic line;
    logic [7:0] rsp_q[$];
    int error_cnt = 0;
    int num_checks = 0;

    // The wire follows the slave while it drives, else the master or bias.
    assign line = (oe_n === 1'b0) ? tx : m_drv;

    always #25 clk = ~clk;

    mfs_slave #(.CYC_PER_MS(20), .GAP_CHARS(1)) mfs_slave_i (
        .clk_i(clk), .sys_rst_i(rst), .rx_i(line), .tx_o(tx),
        .line_oe_n_o(oe_n), .cfg_i(cfg), .cfg_load_i(load),
        .serial_lo_i(serial), .meas_i(meas));
    mfs_master_model mfs_master_model_i (.clk_i(clk), .line_i(line),
        .drv_o(m_drv));

    task automatic final_report();
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction

    // Wraps a message in its check and, for ASCII, in text framing.
    function automatic void frame(input logic asc, input logic [7:0] d[$],
        output logic [7:0] o[$]);
        logic [15:0] c;
        logic [7:0] s;
        c = 16'hffff;
        s = 8'h00;
        o = {};
        foreach (d[i])
        begin
            s = s + d[i];
            c = c ^ {8'h00, d[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        if (!asc)
            o = {d, c[7:0], c[15:8]};
        else
        begin
            o.push_back(8'h3a);
            d.push_back(8'h00 - s);
            foreach (d[i])
            begin
                o.push_back(hexc(d[i][7:4]));
                o.push_back(hexc(d[i][3:0]));
            end
            o.push_back(8'h0d);
            o.push_back(8'h0a);
        end
    endfunction

    task automatic send(input logic [7:0] o[$]);
        foreach (o[i])
            mfs_master_model_i.send_byte(o[i]);
    endtask

    task automatic load_cfg(input logic asc, input logic [2:0] sel,
        input logic [7:0] addr, input logic [7:0] ms);
        @(negedge clk);
        cfg = '{asc, sel, addr, ms};
        load = 1'b1;
        @(negedge clk);
        load = 1'b0;
    endtask

    // Sends a request and compares the whole reply, byte by byte.
    task automatic xfer(input logic asc, input logic [7:0] req[$],
        input logic [7:0] rsp[$]);
        logic [7:0] o[$];
        logic [7:0] e[$];
        logic [7:0] b;
        logic ok;
        int n;
        frame(asc, req, o);
        frame(asc, rsp, e);
        send(o);
        rsp_q = {};
        foreach (e[i])
        begin
            mfs_master_model_i.recv_byte(b, ok);
            check("reply_framing", 32'(ok), 32'h0000_0001);
            if (ok !== 1'b1)
                final_report();
            rsp_q.push_back(b);
            check("reply_byte", 32'(b), 32'(e[i]));
        end
        // The next request may only start once the stop bit is out.
        n = 0;
        while (oe_n !== 1'b1 && n < CHAR)
        begin
            @(negedge clk);
            n++;
        end
        check("reply_release", 32'(oe_n), 32'h0000_0001);
    endtask

    // A frame that must draw no reply: the line stays released.
    task automatic refused(input logic [7:0] req[$], input logic bad);
        logic [7:0] o[$];
        int n;
        n = 0;
        frame(1'b0, req, o);
        if (bad)
            o[o.size() - 2] ^= 8'h01;
        send(o);
        repeat (2 * CHAR)
        begin
            @(negedge clk);
            n += (oe_n === 1'b0);
        end
        check("refused_drive", 32'(n), 32'h0000_0000);
    endtask

    // RTU at the top rate: a refused load, refusals, then a value read.
    task automatic sc_rtu();
        logic [31:0] v;
        v = meas.gas_velocity_value;
        load_cfg(1'b0, 3'h7, 8'hfb, 8'h05);
        load_cfg(1'b0, 3'h0, 8'hfc, 8'h00);
        refused({8'h2a, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}, 1'b0);
        refused({8'hfb, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}, 1'b1);
        xfer(1'b0, {8'hfb, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02},
            {8'hfb, 8'h03, 8'h04, v[15:8], v[7:0], v[31:24], v[23:16]});
        check("msb_host", mfs_master_model_i.to_msb(rsp_q[3], rsp_q[4],
            rsp_q[5], rsp_q[6]), v);
        check("lsb_host", mfs_master_model_i.to_lsb(rsp_q[3], rsp_q[4],
            rsp_q[5], rsp_q[6]),
            {v[7:0], v[15:8], v[23:16], v[31:24]});
    endtask

    // ASCII with no programmed address: the serial digits answer.
    task automatic sc_ascii();
        logic [31:0] a;
        a = meas.surrounding_temperature_value;
        load_cfg(1'b1, 3'h7, 8'h00, 8'h00);
        xfer(1'b1, {8'h2a, 8'h03, 8'h00, 8'h24, 8'h00, 8'h01},
            {8'h2a, 8'h03, 8'h02, a[15:8], a[7:0]});
    endtask

    initial
    begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        sc_rtu();
        sc_ascii();
        final_report();
    end
endmodule
`default_nettype wire
